// ==== crc_pkg.sv ====
package crc_pkg;

    // Reference clock rate and the system clock rate it is divided from.
    localparam int unsigned CRC_REF_HZ = 25_000_000;
    localparam int unsigned CRC_SYS_HZ = 50_000_000;
    localparam logic [7:0] CRC_REF_DIV = 8'(CRC_SYS_HZ / CRC_REF_HZ);
    localparam logic [7:0] CRC_SLOW_DIV = 8'h0A;
    localparam logic [15:0] CRC_TIMER_RESET = 16'hFFFF;
    localparam logic [31:0] CRC_COUNT_RESET = 32'h0000_0000;
    // Cycles that every reset stays asserted after its last cause is gone.
    localparam logic [3:0] CRC_RST_STRETCH = 4'h4;
    localparam logic [7:0] CRC_DIV_RESET = 8'h00;

    typedef enum logic [1:0] {
        CRC_LD_IDLE,
        CRC_LD_WAIT,
        CRC_LD_BUSY
    } crc_ld_state_t;

    typedef struct packed {
        logic digital;
        logic phy1;
        logic phy2;
        logic vphy;
    } crc_rst_out_t;

    typedef struct packed {
        logic phy1_pd;
        logic phy1_edpd;
        logic phy2_pd;
        logic phy2_edpd;
    } crc_pwr_t;

endpackage : crc_pkg

// ==== crc_clk_div.sv ====
`timescale 1ns/1ps

// Divides the system clock into an enable strobe, one cycle long while i_ce stays high.
module crc_clk_div
    import crc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic [7:0] i_div,
    output logic o_tick
);

    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } crc_div_state_t;

    crc_div_state_t st_reg;
    crc_div_state_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (st_reg.cnt >= i_div - 8'h01) begin
            st_next.cnt = CRC_DIV_RESET;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 8'h01;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            st_reg <= '0;
        end else if (i_ce) begin
            st_reg <= st_next;
        end
    end

    assign o_tick = st_reg.tick;

endmodule : crc_clk_div

// ==== crc_top.sv ====
`timescale 1ns/1ps

// Behaviour
// - All module clocks derive from 25MHz reference; here logic runs on the 50MHz system clock, only the strobes come from it.
// - Provide 16-bit timer and 32-bit counter.
// - Resets sorted into chip, multi, single tiers.
// - Power-on reset resets entire chip, PHYs included.
// - External reset pin resets entire chip.
// - Digital reset spares both Ethernet PHYs.
// - Loader starts after resets or reload command.
// - Loader copies EEPROM settings after reset completes.
// - Each PHY has power-down and energy-detect modes.
module crc_top
    import crc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_por_n,
    input wire logic i_ext_reset_pin_n,
    input wire logic i_digital_rst_req,
    input wire logic i_phy1_rst_req,
    input wire logic i_phy2_rst_req,
    input wire logic i_vphy_rst_req,
    input wire logic i_reload_cmd,
    input wire logic i_loader_done,
    input wire logic i_timer_load,
    input wire logic [15:0] i_timer_value,
    input wire logic i_timer_enable,
    input wire crc_pwr_t i_pwr_req,
    input wire logic [1:0] i_energy_detect,
    output crc_rst_out_t o_rst,
    output logic o_ref_tick,
    output logic o_slow_tick,
    output logic [15:0] o_general_timer16,
    output logic o_timer_wrap,
    output logic [31:0] o_free_count,
    output logic o_loader_start,
    output logic o_loader_busy,
    output crc_pwr_t o_power_event_control,
    output logic [1:0] o_phy_powered
);

    ////////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [1:0] por_sync;
        logic [1:0] pin_sync;
        logic [3:0] chip_cnt;
        logic [3:0] dig_cnt;
        logic [3:0] p1_cnt;
        logic [3:0] p2_cnt;
        logic [3:0] vp_cnt;
        crc_rst_out_t rst;
        logic [15:0] timer;
        logic wrap;
        logic [31:0] count;
        crc_ld_state_t ld;
        logic ld_start;
        crc_pwr_t pwr;
        logic [1:0] powered;
    } crc_state_t;

    crc_state_t st_reg;
    crc_state_t st_next;
    logic ref_tick;
    logic slow_tick;
    logic chip_req;
    logic chip_hold;
    logic dig_req;
    logic dig_fall;

    // Reference strobe at 25MHz, and a slower strobe derived from it.
    crc_clk_div u_ref_div (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_div(CRC_REF_DIV),
        .o_tick(ref_tick)
    );

    logic slow_raw;
    crc_clk_div u_slow_div (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce & ref_tick),
        .i_div(CRC_SLOW_DIV),
        .o_tick(slow_raw)
    );
    assign slow_tick = slow_raw & ref_tick;

    // Stretch counter reload or decrement, shared by every reset tier.
    function automatic logic [3:0] stretch(input logic req, input logic [3:0] cnt);
        if (req) begin
            return CRC_RST_STRETCH;
        end else if (cnt != 4'h0) begin
            return cnt - 4'h1;
        end
        return cnt;
    endfunction : stretch

    // The chip tier is taken from the synchronised pins only.
    assign chip_req = !st_reg.por_sync[1] || !st_reg.pin_sync[1];
    assign chip_hold = chip_req || (st_reg.chip_cnt != 4'h0);
    assign dig_req = chip_hold || i_digital_rst_req;
    // Loader starts on the cycle the digital reset is released. It is worked out from the
    // registered count, so the loader logic never reads the next state it helps to build.
    assign dig_fall = st_reg.rst.digital && (st_reg.dig_cnt <= 4'h1) && !dig_req;

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        st_next = st_reg;
        st_next.por_sync = {st_reg.por_sync[0], i_por_n};
        st_next.pin_sync = {st_reg.pin_sync[0], i_ext_reset_pin_n};
        // Tiers: chip, then digital, then per-module; chip feeds digital and every per-module tier, digital feeds only vphy.
        st_next.chip_cnt = stretch(chip_req, st_reg.chip_cnt);
        st_next.dig_cnt = stretch(dig_req, st_reg.dig_cnt);
        // Port 1 and 2 PHY resets follow the whole chip tier, not the digital reset, so that after a
        // chip reset every tier is released on the same edge.
        st_next.p1_cnt = stretch(chip_hold || i_phy1_rst_req, st_reg.p1_cnt);
        st_next.p2_cnt = stretch(chip_hold || i_phy2_rst_req, st_reg.p2_cnt);
        st_next.vp_cnt = stretch(dig_req || i_vphy_rst_req, st_reg.vp_cnt);
        st_next.rst.digital = st_next.dig_cnt != 4'h0;
        st_next.rst.phy1 = st_next.p1_cnt != 4'h0;
        st_next.rst.phy2 = st_next.p2_cnt != 4'h0;
        st_next.rst.vphy = st_next.vp_cnt != 4'h0;

        st_next.wrap = 1'b0;
        if (st_reg.rst.digital) begin
            st_next.timer = CRC_TIMER_RESET;
            st_next.count = CRC_COUNT_RESET;
        end else begin
            if (ref_tick) begin
                st_next.count = st_reg.count + 32'h0000_0001;
            end
            if (i_timer_load) begin
                st_next.timer = i_timer_value;
            end else if (i_timer_enable && slow_tick) begin
                if (st_reg.timer == 16'h0000) begin
                    st_next.timer = CRC_TIMER_RESET;
                    st_next.wrap = 1'b1;
                end else begin
                    st_next.timer = st_reg.timer - 16'h0001;
                end
            end
        end

        st_next.ld_start = 1'b0;
        unique case (st_reg.ld)
            CRC_LD_IDLE: begin
                if (dig_fall || (i_reload_cmd && !st_reg.rst.digital)) begin
                    st_next.ld = CRC_LD_BUSY;
                    st_next.ld_start = 1'b1;
                end else if (st_reg.rst.digital) begin
                    st_next.ld = CRC_LD_WAIT;
                end
            end
            CRC_LD_WAIT: begin
                if (dig_fall) begin
                    st_next.ld = CRC_LD_BUSY;
                    st_next.ld_start = 1'b1;
                end
            end
            CRC_LD_BUSY: begin
                if (dig_req) begin
                    st_next.ld = CRC_LD_WAIT;
                end else if (i_loader_done) begin
                    st_next.ld = CRC_LD_IDLE;
                end
            end
            default: begin
                st_next.ld = CRC_LD_IDLE;
            end
        endcase

        // Power-down controls clear on a PHY reset; energy detect wakes an EDPD PHY.
        if (st_reg.rst.phy1) begin
            st_next.pwr.phy1_pd = 1'b0;
            st_next.pwr.phy1_edpd = 1'b0;
        end else begin
            st_next.pwr.phy1_pd = i_pwr_req.phy1_pd;
            st_next.pwr.phy1_edpd = i_pwr_req.phy1_edpd;
        end
        if (st_reg.rst.phy2) begin
            st_next.pwr.phy2_pd = 1'b0;
            st_next.pwr.phy2_edpd = 1'b0;
        end else begin
            st_next.pwr.phy2_pd = i_pwr_req.phy2_pd;
            st_next.pwr.phy2_edpd = i_pwr_req.phy2_edpd;
        end
        st_next.powered[0] = !st_next.pwr.phy1_pd
            && (!st_next.pwr.phy1_edpd || i_energy_detect[0]);
        st_next.powered[1] = !st_next.pwr.phy2_pd
            && (!st_next.pwr.phy2_edpd || i_energy_detect[1]);
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            st_reg <= '0;
            st_reg.chip_cnt <= CRC_RST_STRETCH;
            st_reg.dig_cnt <= CRC_RST_STRETCH;
            st_reg.p1_cnt <= CRC_RST_STRETCH;
            st_reg.p2_cnt <= CRC_RST_STRETCH;
            st_reg.vp_cnt <= CRC_RST_STRETCH;
            st_reg.rst <= '1;
            st_reg.timer <= CRC_TIMER_RESET;
            st_reg.ld <= CRC_LD_WAIT;
        end else if (i_ce) begin
            st_reg <= st_next;
        end
    end

    assign o_rst = st_reg.rst;
    assign o_ref_tick = ref_tick;
    assign o_slow_tick = slow_tick;
    assign o_general_timer16 = st_reg.timer;
    assign o_timer_wrap = st_reg.wrap;
    assign o_free_count = st_reg.count;
    assign o_loader_start = st_reg.ld_start;
    assign o_loader_busy = st_reg.ld == CRC_LD_BUSY;
    assign o_power_event_control = st_reg.pwr;
    assign o_phy_powered = st_reg.powered;

    ////////////////////////////////////////////////////////////////////////////////

    sequence s_dig_release;
        $fell(st_reg.rst.digital);
    endsequence

    a_chip_tier_digital: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (st_reg.chip_cnt != 4'h0) |-> st_reg.rst.digital)
        else $error("Digital reset low while chip reset active.");
    a_chip_tier_phys: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (st_reg.chip_cnt != 4'h0) |-> (st_reg.rst.phy1 && st_reg.rst.phy2 && st_reg.rst.vphy))
        else $error("PHY reset low while chip reset active.");
    a_pin_reset_chip: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (i_ce && !i_ext_reset_pin_n)[*3] |=> st_reg.rst.digital && st_reg.rst.phy1)
        else $error("Pin reset did not reset the chip.");
    a_digital_spares_phy: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (i_ce && i_digital_rst_req && !chip_req && st_reg.chip_cnt == 4'h0
         && st_reg.p1_cnt == 4'h0 && !i_phy1_rst_req) |=> !st_reg.rst.phy1)
        else $error("Digital reset touched Port 1 PHY.");
    a_phy2_single: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (i_ce && i_phy2_rst_req) |=> st_reg.rst.phy2)
        else $error("Port 2 PHY reset not applied.");
    a_loader_after_rst: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        s_dig_release |-> st_reg.ld_start || !i_ce)
        else $error("Loader did not start after reset release.");
    a_loader_busy_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        $rose(st_reg.ld_start) |=> (o_loader_busy || !i_ce))
        else $error("Loader start without busy.");
    a_counter_step: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (i_ce && ref_tick && !st_reg.rst.digital) |=> o_free_count == $past(o_free_count) + 32'h1)
        else $error("Free counter did not advance.");
    a_powerdown_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (i_ce && i_pwr_req.phy1_pd && !st_reg.rst.phy1) |=> !o_phy_powered[0])
        else $error("Port 1 PHY not powered down.");

endmodule : crc_top

// ==== crc_eeprom_model.sv ====
`timescale 1ns/1ps

// Stands in for the configuration memory behind the loader: it answers each
// start pulse with a single done pulse a fixed number of cycles later.
module crc_eeprom_model #(
    parameter int LOAD_CYCLES = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_loader_start,
    output logic o_loader_done
);
    int count_reg;

    always @(posedge i_sys_clk) begin
        o_loader_done <= 1'b0;
        if (!i_rst_b) begin
            count_reg <= 0;
        end else if (i_loader_start) begin
            count_reg <= LOAD_CYCLES;
        end else if (count_reg != 0) begin
            count_reg <= count_reg - 1;
            o_loader_done <= (count_reg == 1);
        end
    end
endmodule : crc_eeprom_model

// ==== clock_reset_controller_bench.sv ====
`timescale 1ns/1ps

module clock_reset_controller_bench;
    import crc_pkg::*;

    typedef struct packed {
        logic [3:0] req;
        crc_rst_out_t exp;
    } crc_row_t;

    logic clk = 1'b0, rst_b = 1'b0, por_n = 1'b1, pin_n = 1'b1, reload = 1'b0;
    logic [3:0] req_v = 4'h0;
    logic t_load = 1'b0, t_en = 1'b0, ld_done;
    logic [15:0] t_val = 16'h0000;
    crc_pwr_t pwr = 4'h0;
    logic [1:0] energy = 2'b00;
    crc_rst_out_t rst_o;
    logic ref_tick, slow_tick, t_wrap, ld_start, ld_busy;
    logic [15:0] timer;
    logic [31:0] count, c0;
    crc_pwr_t pec;
    logic [1:0] powered;
    int n_errors = 0, checked = 0;
    int n_ref = 0, n_slow = 0;
    logic ce = 1'b1;
    crc_row_t rows [4] = '{
        '{4'h8, 4'h9}, '{4'h4, 4'h4}, '{4'h2, 4'h2}, '{4'h1, 4'h1}};

    always #10 clk = ~clk;

    crc_top uut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_por_n(por_n),
        .i_ext_reset_pin_n(pin_n), .i_digital_rst_req(req_v[3]), .i_phy1_rst_req(req_v[2]),
        .i_phy2_rst_req(req_v[1]), .i_vphy_rst_req(req_v[0]), .i_reload_cmd(reload),
        .i_loader_done(ld_done), .i_timer_load(t_load), .i_timer_value(t_val),
        .i_timer_enable(t_en), .i_pwr_req(pwr), .i_energy_detect(energy), .o_rst(rst_o),
        .o_ref_tick(ref_tick), .o_slow_tick(slow_tick), .o_general_timer16(timer),
        .o_timer_wrap(t_wrap), .o_free_count(count), .o_loader_start(ld_start),
        .o_loader_busy(ld_busy), .o_power_event_control(pec), .o_phy_powered(powered));

    crc_eeprom_model #(.LOAD_CYCLES(8)) model (.i_sys_clk(clk), .i_rst_b(rst_b),
        .i_loader_start(ld_start), .o_loader_done(ld_done));

    ////////////////////////////////////////////////////////////////////////////

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check

    task automatic finish_test;
        $display("errors %0d, comparisons %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test

    function automatic logic cond(input int sel);
        if (sel == 0) return ld_start === 1'b1;
        if (sel == 1) return ld_busy === 1'b0;
        if (sel == 2) return rst_o === 4'hF;
        return t_wrap === 1'b1;
    endfunction : cond

    // A wait that runs out is a hang of the design, so the run is closed here.
    task automatic wait_for(input int sel, input int limit);
        for (int i = 0; i < limit; i++) begin
            @(posedge clk);
            #1;
            if (cond(sel)) return;
        end
        n_errors++;
        $display("wrong value at %0t: wait %0d ran out", $time, sel);
        finish_test();
    endtask : wait_for

    ////////////////////////////////////////////////////////////////////////////

    initial begin
        @(posedge clk);
        #1;
        check(rst_o, 4'hF, "resets in reset");
        check(count, 32'h0, "counter in reset");
        check(timer, CRC_TIMER_RESET, "timer in reset");
        @(posedge clk);
        rst_b <= 1'b1;
        wait_for(0, 30);
        check(rst_o, 4'h0, "all tiers leave reset together");
        check(ld_busy, 1'b1, "busy after start");
        wait_for(1, 20);
        foreach (rows[i]) begin
            @(posedge clk);
            req_v <= rows[i].req;
            @(posedge clk);
            req_v <= 4'h0;
            #1;
            check(rst_o, rows[i].exp, "request reset row");
            repeat (20) @(posedge clk);
        end
        // Reload is taken when idle and refused while the loader is busy.
        @(posedge clk);
        reload <= 1'b1;
        @(posedge clk);
        reload <= 1'b0;
        #1;
        check(ld_start, 1'b1, "reload starts loader");
        @(posedge clk);
        reload <= 1'b1;
        @(posedge clk);
        reload <= 1'b0;
        repeat (3) begin
            #1;
            check(ld_start, 1'b0, "reload while busy");
            @(posedge clk);
        end
        wait_for(1, 20);
        @(posedge clk);
        pin_n <= 1'b0;
        wait_for(2, 6);
        repeat (4) @(posedge clk);
        pin_n <= 1'b1;
        wait_for(0, 20);
        wait_for(1, 20);
        @(posedge clk);
        por_n <= 1'b0;
        wait_for(2, 6);
        repeat (4) @(posedge clk);
        por_n <= 1'b1;
        wait_for(0, 20);
        wait_for(1, 20);
        #1;
        c0 = count;
        repeat (20) @(posedge clk);
        #1;
        check(count - c0, 32'd10, "count per reference tick");
        repeat (40) begin
            @(posedge clk);
            #1;
            n_ref += ref_tick;
            n_slow += slow_tick;
        end
        check(n_ref, 32'h0000_0014, "reference ticks in 40 cycles");
        check(n_slow, 32'h0000_0002, "slow ticks in 40 cycles");
        @(posedge clk);
        ce <= 1'b0;
        #1;
        c0 = count;
        repeat (6) @(posedge clk);
        #1;
        check(count, c0, "count frozen while enable low");
        @(posedge clk);
        ce <= 1'b1;
        @(posedge clk);
        t_val <= 16'h1234;
        t_load <= 1'b1;
        @(posedge clk);
        t_load <= 1'b0;
        #1;
        check(timer, 16'h1234, "timer load");
        @(posedge clk);
        t_val <= 16'h0002;
        t_load <= 1'b1;
        t_en <= 1'b1;
        @(posedge clk);
        t_load <= 1'b0;
        #1;
        check(timer, 16'h0002, "timer load while enabled");
        wait_for(3, 80);
        check(timer, CRC_TIMER_RESET, "timer after wrap");
        @(posedge clk);
        t_en <= 1'b0;
        @(posedge clk);
        pwr <= 4'b1001;
        repeat (3) @(posedge clk);
        #1;
        check(pec, 4'b1001, "power control copy");
        check(powered, 2'b00, "powered down");
        @(posedge clk);
        energy <= 2'b10;
        repeat (3) @(posedge clk);
        #1;
        check(powered, 2'b10, "energy wakes port 2");
        finish_test();
    end
endmodule : clock_reset_controller_bench
